// ===== tds_sequencer.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// RL1: The genset start delay counts whole seconds up to 15 on basic controls and up to 120 on advanced ones.
// RL2: The genset start delay is three seconds unless software sets another value.
// RL3: Losing source 1 starts the start delay and the genset is started only if the loss outlasts it.
// RL4: The cool-down delay counts whole minutes up to 30 and is ten minutes by default.
// RL5: Cool-down starts once the load is back on source 1 and its end sends the genset stop.
// RL6: The transfer delay starts when source 2 is acceptable and its end commands the move to source 2.
// RL7: The transfer delay counts whole seconds up to 120 and is ten seconds by default.
// RL8: With two utilities the transfer delay times the move to backup and the retransfer delay the move back.
// RL9: The retransfer delay starts when source 1 returns and retransfer is allowed only after it ends.
// RL10: The retransfer delay counts whole minutes up to 30 and is ten minutes by default.
// RL11: Each move dwells in neutral for the programmed time before the new source is connected.
// RL12: The neutral dwell counts whole seconds up to 60, is zero by default and is enabled by default.
// RL13: Each move is preceded by the elevator warning held for the elevator pre-transfer time.
// RL14: The elevator delay counts whole seconds up to 60, is zero by default and is enabled by default.
// RL15: Every delay is writable by software, which keeps each value within its range; the block itself only cuts a write to the register width.
// RL16: All timers count one shared one-second tick and minute delays compare against sixty ticks a minute.
module tds_sequencer
   import tds_pkg::*;
#(
   parameter int TICK_CYCLES = TDS_TICK_CYCLES
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   input  wire logic [TDS_AW-1:0] addr,
   input  wire logic [TDS_DW-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [TDS_DW-1:0] rd_data,
   input  wire logic              src1_ok,
   input  wire logic              src2_ok,
   input  wire logic              pos_s1,
   input  wire logic              pos_s2,
   input  wire logic              pos_neutral,
   output logic                   genset_start,
   output logic                   genset_stop,
   output logic                   elev_warn,
   output logic                   cmd_neutral,
   output logic                   cmd_close_s2,
   output logic                   cmd_close_s1
);

   tds_cfg_s           cfg_ff;
   tds_out_s           out_ff;
   tds_out_s           nxt_out;
   tds_state_e         state_ff;
   tds_state_e         nxt_state;
   logic               to_s2_ff;
   logic               nxt_to_s2;
   logic               run_ff;
   logic               nxt_run;
   logic [TDS_DW-1:0]  rd_data_ff;
   logic               tick;
   logic               tmr_done;
   logic [TDS_TW-1:0]  tmr_limit;

   // Register decode
   wire wr_start  = wr_en && (addr == TDS_ADDR_START);
   wire wr_cool   = wr_en && (addr == TDS_ADDR_COOL);
   wire wr_backup = wr_en && (addr == TDS_ADDR_TO_BACKUP);
   wire wr_pref   = wr_en && (addr == TDS_ADDR_TO_PREF);
   wire wr_dwell  = wr_en && (addr == TDS_ADDR_DWELL);
   wire wr_elev   = wr_en && (addr == TDS_ADDR_ELEV);
   wire wr_ctrl   = wr_en && (addr == TDS_ADDR_CTRL);

   wire [TDS_DW-1:0] ctrl_word = {12'h000, cfg_ff.elev_en, cfg_ff.dwell_en, cfg_ff.util_mode, cfg_ff.level_adv};
   wire [TDS_DW-1:0] stat_word = {out_ff, state_ff};
   wire [TDS_DW-1:0] rd_mux    =
      (addr == TDS_ADDR_START)     ? {9'h000,  cfg_ff.genset_start_delay}     :
      (addr == TDS_ADDR_COOL)      ? {11'h000, cfg_ff.cooldown_stop_delay}    :
      (addr == TDS_ADDR_TO_BACKUP) ? {9'h000,  cfg_ff.to_backup_delay}        :
      (addr == TDS_ADDR_TO_PREF)   ? {11'h000, cfg_ff.to_preferred_delay}     :
      (addr == TDS_ADDR_DWELL)     ? {10'h000, cfg_ff.neutral_dwell_delay}    :
      (addr == TDS_ADDR_ELEV)      ? {10'h000, cfg_ff.elevator_warning_delay} :
      (addr == TDS_ADDR_CTRL)      ? ctrl_word : stat_word;

   // Basic controls never use a start delay above the basic maximum
   wire [6:0] start_eff = (!cfg_ff.level_adv && cfg_ff.genset_start_delay > TDS_BASIC_START_MAX) ?
                          TDS_BASIC_START_MAX : cfg_ff.genset_start_delay;                 // [RL1]

   // Minute delays scaled to ticks
   wire [TDS_TW-1:0] cool_ticks = TDS_TW'(cfg_ff.cooldown_stop_delay) * TDS_SEC_PER_MIN;  // [RL16]
   wire [TDS_TW-1:0] pref_ticks = TDS_TW'(cfg_ff.to_preferred_delay) * TDS_SEC_PER_MIN;   // [RL16]

   assign tmr_limit =
      (state_ff == ST_START_WT)  ? TDS_TW'(start_eff)                     :
      (state_ff == ST_BACKUP_WT) ? TDS_TW'(cfg_ff.to_backup_delay)        :
      (state_ff == ST_PREF_WT)   ? pref_ticks                             :
      (state_ff == ST_COOLDOWN)  ? cool_ticks                             :
      (state_ff == ST_DWELL)     ? TDS_TW'(cfg_ff.neutral_dwell_delay)    :
      (state_ff == ST_ELEV)      ? TDS_TW'(cfg_ff.elevator_warning_delay) : '0;

   // Backup wait restarts while source 2 is not yet acceptable
   wire tmr_restart = (nxt_state != state_ff) || (state_ff == ST_BACKUP_WT && !src2_ok);  // [RL6]
   wire move_start  = cfg_ff.elev_en;

   tds_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .tick    (tick)
   );

   tds_delay_timer #(
      .W (TDS_TW)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .tick    (tick),
      .restart (tmr_restart),
      .limit   (tmr_limit),
      .done    (tmr_done)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_to_s2 = to_s2_ff;
      nxt_run   = run_ff;
      case (state_ff)
         ST_ON_S1: begin
            // No genset to start between two utilities
            if (!src1_ok)
               nxt_state = cfg_ff.util_mode ? ST_BACKUP_WT : ST_START_WT;            // [RL8]
         end
         ST_START_WT: begin
            if (src1_ok)
               nxt_state = ST_ON_S1;                                                  // [RL3]
            else if (tmr_done) begin
               nxt_run   = 1'b1;                                                      // [RL3]
               nxt_state = ST_BACKUP_WT;
            end
         end
         ST_BACKUP_WT: begin
            if (src1_ok)
               nxt_state = run_ff ? ST_COOLDOWN : ST_ON_S1;
            else if (src2_ok && tmr_done) begin
               nxt_to_s2 = 1'b1;
               nxt_state = move_start ? ST_ELEV : ST_NEUTRAL;                        // [RL6] [RL13]
            end
         end
         ST_ELEV: begin
            if (tmr_done)
               nxt_state = ST_NEUTRAL;                                                // [RL13]
         end
         ST_NEUTRAL: begin
            if (pos_neutral)
               nxt_state = cfg_ff.dwell_en ? ST_DWELL : ST_CLOSE;                    // [RL11]
         end
         ST_DWELL: begin
            if (tmr_done)
               nxt_state = ST_CLOSE;                                                  // [RL11]
         end
         ST_CLOSE: begin
            if (to_s2_ff && pos_s2)
               nxt_state = ST_ON_S2;
            else if (!to_s2_ff && pos_s1)
               nxt_state = run_ff ? ST_COOLDOWN : ST_ON_S1;                          // [RL5]
         end
         ST_ON_S2: begin
            if (src1_ok)
               nxt_state = ST_PREF_WT;                                                // [RL9]
         end
         ST_PREF_WT: begin
            if (!src1_ok)
               nxt_state = ST_ON_S2;                                                  // [RL9]
            else if (tmr_done) begin
               nxt_to_s2 = 1'b0;
               nxt_state = move_start ? ST_ELEV : ST_NEUTRAL;                        // [RL9] [RL13]
            end
         end
         ST_COOLDOWN: begin
            // Source 1 lost again while the genset still runs
            if (!src1_ok)
               nxt_state = ST_BACKUP_WT;
            else if (tmr_done) begin
               nxt_run   = 1'b0;                                                      // [RL5]
               nxt_state = ST_ON_S1;
            end
         end
         default: begin
            nxt_state = ST_ON_S1;
         end
      endcase
   end

   // Outputs follow the next state so they line up with it
   assign nxt_out.genset_start = nxt_run;
   assign nxt_out.genset_stop  = run_ff && !nxt_run;                                  // [RL5]
   assign nxt_out.elev_warn    = (nxt_state == ST_ELEV);                              // [RL13]
   assign nxt_out.cmd_neutral  = (nxt_state == ST_NEUTRAL);
   assign nxt_out.cmd_close_s2 = (nxt_state == ST_CLOSE) && nxt_to_s2;               // [RL11]
   assign nxt_out.cmd_close_s1 = (nxt_state == ST_CLOSE) && !nxt_to_s2;              // [RL11]

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff <= ST_ON_S1;
         to_s2_ff <= 1'b0;
         run_ff   <= 1'b0;
         out_ff   <= '0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         to_s2_ff <= nxt_to_s2;
         run_ff   <= nxt_run;
         out_ff   <= nxt_out;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_ff.genset_start_delay     <= TDS_RST_START;                              // [RL2]
         cfg_ff.cooldown_stop_delay    <= TDS_RST_COOL;                               // [RL4]
         cfg_ff.to_backup_delay        <= TDS_RST_TO_BACKUP;                          // [RL7]
         cfg_ff.to_preferred_delay     <= TDS_RST_TO_PREF;                            // [RL10]
         cfg_ff.neutral_dwell_delay    <= TDS_RST_DWELL;                              // [RL12]
         cfg_ff.elevator_warning_delay <= TDS_RST_ELEV;                               // [RL14]
         cfg_ff.level_adv              <= TDS_RST_ADV;
         cfg_ff.util_mode              <= TDS_RST_UTIL;
         cfg_ff.dwell_en               <= TDS_RST_DWELL_EN;                           // [RL12]
         cfg_ff.elev_en                <= TDS_RST_ELEV_EN;                            // [RL14]
      end else if (clk_en) begin
         if (wr_start)  cfg_ff.genset_start_delay     <= wr_data[6:0];                // [RL15]
         if (wr_cool)   cfg_ff.cooldown_stop_delay    <= wr_data[4:0];                // [RL15]
         if (wr_backup) cfg_ff.to_backup_delay        <= wr_data[6:0];                // [RL15]
         if (wr_pref)   cfg_ff.to_preferred_delay     <= wr_data[4:0];                // [RL15]
         if (wr_dwell)  cfg_ff.neutral_dwell_delay    <= wr_data[5:0];                // [RL15]
         if (wr_elev)   cfg_ff.elevator_warning_delay <= wr_data[5:0];                // [RL15]
         if (wr_ctrl) begin
            cfg_ff.level_adv <= wr_data[TDS_CTRL_ADV_BIT];
            cfg_ff.util_mode <= wr_data[TDS_CTRL_UTIL_BIT];
            cfg_ff.dwell_en  <= wr_data[TDS_CTRL_DWELL_BIT];
            cfg_ff.elev_en   <= wr_data[TDS_CTRL_ELEV_BIT];
         end
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst)
         rd_data_ff <= '0;
      else if (clk_en)
         rd_data_ff <= rd_en ? rd_mux : '0;
   end

   assign rd_data      = rd_data_ff;
   assign genset_start = out_ff.genset_start;
   assign genset_stop  = out_ff.genset_stop;
   assign elev_warn    = out_ff.elev_warn;
   assign cmd_neutral  = out_ff.cmd_neutral;
   assign cmd_close_s2 = out_ff.cmd_close_s2;
   assign cmd_close_s1 = out_ff.cmd_close_s1;

   sequence dwell_leave_s;
      clk_en && state_ff == ST_DWELL && tmr_done;
   endsequence

   sequence close_enter_s;
      state_ff == ST_CLOSE;
   endsequence

   chk_basic_clamp: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
      !cfg_ff.level_adv |-> start_eff <= TDS_BASIC_START_MAX) else $error("basic start delay above limit");

   chk_reset_dflt: assert property (@(posedge sys_clk) // [RL2]
      $fell(rst) |-> cfg_ff.genset_start_delay == 7'h03 && cfg_ff.cooldown_stop_delay == 5'h0A
                     && cfg_ff.to_backup_delay == 7'h0A && cfg_ff.dwell_en && cfg_ff.elev_en)
      else $error("delay defaults wrong after reset");

   chk_start_cause: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
      $rose(genset_start) |-> $past(state_ff) == ST_START_WT && $past(tmr_done) && !$past(src1_ok))
      else $error("genset started without expired start delay");

   chk_brief_loss: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
      (clk_en && state_ff == ST_START_WT && src1_ok) |=> state_ff == ST_ON_S1 && !run_ff)
      else $error("brief outage not ignored");

   chk_stop_cause: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
      $rose(genset_stop) |-> $past(state_ff) == ST_COOLDOWN && $past(tmr_done) ##1 !genset_stop)
      else $error("genset stop outside cool-down end");

   chk_minute_scale: assert property (@(posedge sys_clk) disable iff (rst) // [RL16]
      state_ff == ST_COOLDOWN |-> tmr_limit == 11'(cfg_ff.cooldown_stop_delay) * 11'h03C)
      else $error("cool-down limit not scaled to minutes");

   chk_pref_abort: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
      (clk_en && state_ff == ST_PREF_WT && !src1_ok) |=> state_ff == ST_ON_S2 && !cmd_close_s1)
      else $error("retransfer wait not aborted");

   chk_dwell_close: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
      dwell_leave_s |=> close_enter_s ##0 (cmd_close_s1 || cmd_close_s2))
      else $error("no close after neutral dwell");

   chk_close_after: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
      ($rose(cmd_close_s2) && cfg_ff.dwell_en) |-> $past(state_ff) == ST_DWELL)
      else $error("close without neutral dwell");

   chk_elev_first: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
      ($rose(cmd_neutral) && cfg_ff.elev_en) |-> $past(elev_warn))
      else $error("move without elevator warning");

endmodule : tds_sequencer

// ===== tds_pkg.sv
package tds_pkg;

   localparam int          TDS_DW              = 16;
   localparam int          TDS_AW              = 3;
   localparam int          TDS_TW              = 11;

   // Clock rate and the one-second tick
   localparam int          TDS_CLK_FREQ_KHZ    = 40000;
   localparam int          TDS_TICK_PERIOD_MS  = 1000;
   localparam int          TDS_TICK_CYCLES     = TDS_TICK_PERIOD_MS * TDS_CLK_FREQ_KHZ;
   localparam logic [10:0] TDS_SEC_PER_MIN     = 11'h03C;
   localparam logic [6:0]  TDS_BASIC_START_MAX = 7'h0F;

   // Register offsets
   localparam logic [2:0]  TDS_ADDR_START      = 3'h0;
   localparam logic [2:0]  TDS_ADDR_COOL       = 3'h1;
   localparam logic [2:0]  TDS_ADDR_TO_BACKUP  = 3'h2;
   localparam logic [2:0]  TDS_ADDR_TO_PREF    = 3'h3;
   localparam logic [2:0]  TDS_ADDR_DWELL      = 3'h4;
   localparam logic [2:0]  TDS_ADDR_ELEV       = 3'h5;
   localparam logic [2:0]  TDS_ADDR_CTRL       = 3'h6;
   localparam logic [2:0]  TDS_ADDR_STATUS     = 3'h7;

   // Control field positions
   localparam int          TDS_CTRL_ADV_BIT    = 0;
   localparam int          TDS_CTRL_UTIL_BIT   = 1;
   localparam int          TDS_CTRL_DWELL_BIT  = 2;
   localparam int          TDS_CTRL_ELEV_BIT   = 3;

   // Values after reset
   localparam logic [6:0]  TDS_RST_START       = 7'h03;
   localparam logic [4:0]  TDS_RST_COOL        = 5'h0A;
   localparam logic [6:0]  TDS_RST_TO_BACKUP   = 7'h0A;
   localparam logic [4:0]  TDS_RST_TO_PREF     = 5'h0A;
   localparam logic [5:0]  TDS_RST_DWELL       = 6'h00;
   localparam logic [5:0]  TDS_RST_ELEV        = 6'h00;
   localparam logic        TDS_RST_ADV         = 1'b0;
   localparam logic        TDS_RST_UTIL        = 1'b0;
   localparam logic        TDS_RST_DWELL_EN    = 1'b1;
   localparam logic        TDS_RST_ELEV_EN     = 1'b1;

   typedef struct packed {
      logic [6:0] genset_start_delay;
      logic [4:0] cooldown_stop_delay;
      logic [6:0] to_backup_delay;
      logic [4:0] to_preferred_delay;
      logic [5:0] neutral_dwell_delay;
      logic [5:0] elevator_warning_delay;
      logic       level_adv;
      logic       util_mode;
      logic       dwell_en;
      logic       elev_en;
   } tds_cfg_s;

   typedef struct packed {
      logic genset_start;
      logic genset_stop;
      logic elev_warn;
      logic cmd_neutral;
      logic cmd_close_s2;
      logic cmd_close_s1;
   } tds_out_s;

   typedef enum logic [9:0] {
      ST_ON_S1     = 10'h001,
      ST_START_WT  = 10'h002,
      ST_BACKUP_WT = 10'h004,
      ST_ELEV      = 10'h008,
      ST_NEUTRAL   = 10'h010,
      ST_DWELL     = 10'h020,
      ST_CLOSE     = 10'h040,
      ST_ON_S2     = 10'h080,
      ST_PREF_WT   = 10'h100,
      ST_COOLDOWN  = 10'h200
   } tds_state_e;

endpackage : tds_pkg

// ===== tds_tick_gen.sv
`timescale 1ns/10ps
module tds_tick_gen
   import tds_pkg::*;
#(
   parameter int TICK_CYCLES = TDS_TICK_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   output logic      tick
);

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   wire         wrap = (cnt_ff == 32'(TICK_CYCLES - 1));

   assign nxt_cnt = wrap ? 32'h0 : cnt_ff + 32'h1;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_ff <= 32'h0;
         tick   <= 1'b0;
      end else if (clk_en) begin
         cnt_ff <= nxt_cnt;
         tick   <= wrap;
      end
   end

endmodule : tds_tick_gen

// ===== tds_delay_timer.sv
`timescale 1ns/10ps
module tds_delay_timer
   import tds_pkg::*;
#(
   parameter int W = TDS_TW
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   input  wire logic         tick,
   input  wire logic         restart,
   input  wire logic [W-1:0] limit,
   output logic              done
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   // Tick phase is free-running, so one extra tick is counted:
   // a delay of N never ends before N full seconds have passed
   assign nxt_cnt = restart                  ? '0 :
                    (tick && cnt_ff <= limit) ? cnt_ff + W'(1) : cnt_ff;
   assign done    = (limit == '0) || (cnt_ff > limit);

   always_ff @(posedge sys_clk) begin
      if (rst)
         cnt_ff <= '0;
      else if (clk_en)
         cnt_ff <= nxt_cnt;
   end

endmodule : tds_delay_timer

// ===== tds_switch_model.sv
`timescale 1ns/10ps
// Switch mechanism: moves to the commanded position LAT+1 cycles after a command starts from idle, one cycle after a command that directly follows another
module tds_switch_model
   import tds_pkg::*;
#(
   parameter int LAT = 3
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic cmd_neutral,
   input  wire logic cmd_close_s2,
   input  wire logic cmd_close_s1,
   output logic      pos_s1,
   output logic      pos_s2,
   output logic      pos_neutral
);
   int  move_ff;
   wire moving = cmd_neutral | cmd_close_s2 | cmd_close_s1;

   // Contacts open at neutral before either source closes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         move_ff     <= 0;
         pos_s1      <= 1'b1;
         pos_s2      <= 1'b0;
         pos_neutral <= 1'b0;
      end else if (!moving) begin
         move_ff <= 0;
      end else if (move_ff < LAT) begin
         move_ff <= move_ff + 1;
      end else begin
         pos_neutral <= cmd_neutral;
         pos_s2      <= cmd_close_s2;
         pos_s1      <= cmd_close_s1;
      end
   end
endmodule : tds_switch_model

// ===== tds_sequencer_tb.sv
`timescale 1ns/10ps
module tds_sequencer_tb;
   import tds_pkg::*;
   localparam int T = 10;
   localparam int GS = 5, STP = 4, EW = 3, NEU = 2, CS2 = 1, CS1 = 0;

   logic              sys_clk, rst, wr_en, rd_en, src1_ok, src2_ok, clk_en;
   logic [TDS_AW-1:0] addr;
   logic [TDS_DW-1:0] wr_data;
   wire  [TDS_DW-1:0] rd_data;
   wire               pos_s1, pos_s2, pos_neutral;
   wire               genset_start, genset_stop, elev_warn, cmd_neutral, cmd_close_s2, cmd_close_s1;
   wire  [5:0]        outs = {genset_start, genset_stop, elev_warn, cmd_neutral, cmd_close_s2, cmd_close_s1};
   int                bad_count, check_count, n, i;
   logic              seen;
   logic [15:0]       dflt [8] = '{16'h0003, 16'h000A, 16'h000A, 16'h000A, 16'h0000, 16'h0000, 16'h000C, 16'h0001};

   tds_sequencer #(.TICK_CYCLES(T)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .src1_ok(src1_ok),
      .src2_ok(src2_ok), .pos_s1(pos_s1), .pos_s2(pos_s2), .pos_neutral(pos_neutral),
      .genset_start(genset_start), .genset_stop(genset_stop), .elev_warn(elev_warn),
      .cmd_neutral(cmd_neutral), .cmd_close_s2(cmd_close_s2), .cmd_close_s1(cmd_close_s1));

   tds_switch_model #(.LAT(3)) sw (.sys_clk(sys_clk), .rst(rst), .cmd_neutral(cmd_neutral),
      .cmd_close_s2(cmd_close_s2), .cmd_close_s1(cmd_close_s1), .pos_s1(pos_s1), .pos_s2(pos_s2),
      .pos_neutral(pos_neutral));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
      check_count++;
      if (seen_v !== exp_v) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask : chk

   // Cycle counts are bench values, not design values
   task automatic rng(input int cnt, input int lo, input int hi);
      check_count++;
      if (cnt < lo || cnt > hi) begin
         bad_count++;
         $display("[FAIL] %0t delay %0d cycles outside %0d..%0d", $time, cnt, lo, hi);
      end
   endtask : rng

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge sys_clk);
      wr_en   <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp_v);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      chk(rd_data, exp_v);
   endtask : rd_chk

   task automatic wait_bit(input int idx, input logic v, input int maxc, output int cnt);
      cnt = 0;
      while (outs[idx] !== v && cnt < maxc) begin
         @(negedge sys_clk);
         cnt++;
      end
      if (outs[idx] !== v) begin
         bad_count++;
         $display("[FAIL] %0t timeout on output %0d", $time, idx);
         final_report();
      end
   endtask : wait_bit

   task automatic set_src(input logic s1, input logic s2);
      @(posedge sys_clk);
      src1_ok <= s1;
      src2_ok <= s2;
   endtask : set_src

   initial begin
      rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = '0; wr_data = '0; src1_ok = 1'b1; src2_ok = 1'b0;
      bad_count = 0; check_count = 0; clk_en = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 8; i++) rd_chk(i[2:0], dflt[i]);
      wr(TDS_ADDR_TO_BACKUP, 16'hFFFF);
      rd_chk(TDS_ADDR_TO_BACKUP, 16'h007F);
      wr(TDS_ADDR_STATUS, 16'hFFFF);
      rd_chk(TDS_ADDR_STATUS, 16'h0001);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(TDS_ADDR_DWELL, 16'h0005);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd_chk(TDS_ADDR_DWELL, 16'h0000);
      $display("test registers done");

      // Outage shorter than the 3 s default start delay
      set_src(1'b0, 1'b0);
      seen = 1'b0;
      repeat (2 * T) begin
         @(negedge sys_clk);
         seen = seen | genset_start;
      end
      set_src(1'b1, 1'b0);
      repeat (3 * T) @(negedge sys_clk);
      chk({15'h0, seen}, 16'h0000);
      rd_chk(TDS_ADDR_STATUS, 16'h0001);
      $display("test brief outage done");

      // Full transfer and retransfer, basic level clamps 20 s to 15 s
      wr(TDS_ADDR_START, 16'h0014);
      wr(TDS_ADDR_TO_BACKUP, 16'h0001);
      wr(TDS_ADDR_TO_PREF, 16'h0001);
      wr(TDS_ADDR_COOL, 16'h0001);
      wr(TDS_ADDR_ELEV, 16'h0001);
      wr(TDS_ADDR_DWELL, 16'h0001);
      set_src(1'b0, 1'b0);
      wait_bit(GS, 1'b1, 400, n);
      rng(n, 15 * T, 16 * T + 4);
      repeat (5 * T) @(negedge sys_clk);
      chk({15'h0, elev_warn}, 16'h0000);
      set_src(1'b0, 1'b1);
      wait_bit(EW, 1'b1, 100, n);
      rng(n, T, 2 * T + 4);
      wait_bit(EW, 1'b0, 100, n);
      rng(n, T - 1, 2 * T + 4);
      chk({15'h0, cmd_neutral}, 16'h0001);
      wait_bit(CS2, 1'b1, 100, n);
      rng(n, T + 3, 2 * T + 8);
      wait_bit(CS2, 1'b0, 20, n);
      rd_chk(TDS_ADDR_STATUS, 16'h8080);
      set_src(1'b1, 1'b1);
      wait_bit(EW, 1'b1, 1000, n);
      rng(n, 60 * T, 61 * T + 4);
      wait_bit(CS1, 1'b1, 200, n);
      wait_bit(CS1, 1'b0, 20, n);
      chk({15'h0, genset_start}, 16'h0001);
      wait_bit(STP, 1'b1, 1000, n);
      rng(n, 60 * T, 61 * T + 4);
      @(negedge sys_clk);
      chk({14'h0, genset_stop, genset_start}, 16'h0000);
      rd_chk(TDS_ADDR_STATUS, 16'h0001);
      $display("test genset transfer done");

      // Two utilities, no elevator warning and no dwell
      wr(TDS_ADDR_CTRL, 16'h0002);
      set_src(1'b0, 1'b1);
      wait_bit(NEU, 1'b1, 100, n);
      rng(n, T, 2 * T + 4);
      chk({15'h0, genset_start}, 16'h0000);
      wait_bit(CS2, 1'b1, 20, n);
      rng(n, 3, 8);
      wait_bit(CS2, 1'b0, 20, n);
      set_src(1'b1, 1'b1);
      wait_bit(NEU, 1'b1, 1000, n);
      rng(n, 60 * T, 61 * T + 4);
      wait_bit(CS1, 1'b1, 20, n);
      wait_bit(CS1, 1'b0, 20, n);
      @(negedge sys_clk);
      rd_chk(TDS_ADDR_STATUS, 16'h0001);
      $display("test utility transfer done");
      final_report();
   end
endmodule : tds_sequencer_tb
